// File: design/crc8_word_pkg.sv
/*
 Constants for the per-word 8-bit checksum engine.
 Assumes a single 100 MHz clock domain and byte-wide streams.
*/
// What this block does
// - Every data word followed by one checksum
// - Checksum covers only this word's two bytes
// - Command words carry no checksum byte
// - Width 8, poly 0x31, seed 0xFF, xorout 0x00
// - Byte XORed in, MSB-first, no reflection
// - Generate on transmit, check on receive
package crc8_word_pkg;
   localparam logic [7:0] CRC_POLY = 8'h31;     // Generator polynomial
   localparam logic [7:0] CRC_SEED = 8'hff;     // Start value per word
   localparam logic [7:0] CRC_XOROUT = 8'h00;   // Final mask
   localparam logic [7:0] CRC_TOP = 8'h80;      // Top bit of register
   localparam logic [1:0] BYTES_PER_WORD = 2'h2; // Data bytes per word
   localparam logic [1:0] POS_RESET = 2'h0;     // Byte position after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;   // Output byte after reset

   // Position of a byte inside a data word
   typedef enum logic [1:0] {POS_MSB, POS_LSB, POS_CRC} word_pos_t;
endpackage

// File: design/crc8_word_engine.sv
/*
 Per-word checksum generator (transmit) and checker (receive).
 Assumes the framing logic marks command bytes and delivers data
 bytes on the same clock; byte strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module crc8_word_engine
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   // Transmit side: data bytes in, bytes out with checksum inserted
   input wire logic TX_VALID,
   input wire logic TX_CMD,
   input wire logic [7:0] TX_BYTE,
   output logic TX_OUT_VALID,
   output logic [7:0] TX_OUT_BYTE,
   output logic TX_OUT_IS_CRC,
   output logic TX_READY,
   // Receive side: raw bytes in, word checked on the checksum byte
   input wire logic RX_VALID,
   input wire logic RX_CMD,
   input wire logic [7:0] RX_BYTE,
   output logic RX_WORD_VALID,
   output logic [15:0] RX_WORD,
   output logic RX_CRC_ERR
);
   // Fold one byte into the register, MSB first
   function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                           input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++)
      begin
         if ((c & crc8_word_pkg::CRC_TOP) != 8'h00)
            c = {c[6:0], 1'b0} ^ crc8_word_pkg::CRC_POLY;
         else
            c = {c[6:0], 1'b0};
      end
      return c;
   endfunction

   // Transmit state
   crc8_word_pkg::word_pos_t tx_pos_ff, nxt_tx_pos;
   logic [7:0] tx_crc_ff, nxt_tx_crc; // Running checksum
   logic tx_ov_ff, nxt_tx_ov;
   logic [7:0] tx_ob_ff, nxt_tx_ob;
   logic tx_oc_ff, nxt_tx_oc;
   logic tx_rdy_ff, nxt_tx_rdy;

   // Transmit next-state logic
   always_comb
   begin
      nxt_tx_pos = tx_pos_ff;
      nxt_tx_crc = tx_crc_ff;
      nxt_tx_ov = 1'b0;
      nxt_tx_ob = tx_ob_ff;
      nxt_tx_oc = 1'b0;
      nxt_tx_rdy = tx_rdy_ff;
      unique case (tx_pos_ff)
         crc8_word_pkg::POS_MSB:
         begin
            if (TX_VALID && TX_CMD)
            begin
               // Command byte passes with no checksum
               nxt_tx_ov = 1'b1;
               nxt_tx_ob = TX_BYTE;
            end
            else if (TX_VALID)
            begin
               nxt_tx_ov = 1'b1;
               nxt_tx_ob = TX_BYTE;
               // Fresh seed for every data word
               nxt_tx_crc = crc_byte(crc8_word_pkg::CRC_SEED,
                                     TX_BYTE);
               nxt_tx_pos = crc8_word_pkg::POS_LSB;
            end
         end
         crc8_word_pkg::POS_LSB:
         begin
            if (TX_VALID)
            begin
               nxt_tx_ov = 1'b1;
               nxt_tx_ob = TX_BYTE;
               nxt_tx_crc = crc_byte(tx_crc_ff, TX_BYTE);
               nxt_tx_pos = crc8_word_pkg::POS_CRC;
               nxt_tx_rdy = 1'b0; // Hold off input while checksum goes out
            end
         end
         crc8_word_pkg::POS_CRC:
         begin
            // Insert checksum right after the word
            nxt_tx_ov = 1'b1;
            nxt_tx_oc = 1'b1;
            nxt_tx_ob = tx_crc_ff ^ crc8_word_pkg::CRC_XOROUT;
            nxt_tx_pos = crc8_word_pkg::POS_MSB;
            nxt_tx_rdy = 1'b1;
         end
      endcase
   end

   // Transmit registers
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         tx_pos_ff <= crc8_word_pkg::POS_MSB;
         tx_crc_ff <= crc8_word_pkg::CRC_SEED;
         tx_ov_ff <= 1'b0;
         tx_ob_ff <= crc8_word_pkg::BYTE_RESET;
         tx_oc_ff <= 1'b0;
         tx_rdy_ff <= 1'b1;
      end
      else if (CE)
      begin
         tx_pos_ff <= nxt_tx_pos;
         tx_crc_ff <= nxt_tx_crc;
         tx_ov_ff <= nxt_tx_ov;
         tx_ob_ff <= nxt_tx_ob;
         tx_oc_ff <= nxt_tx_oc;
         tx_rdy_ff <= nxt_tx_rdy;
      end
   end

   assign TX_OUT_VALID = tx_ov_ff;
   assign TX_OUT_BYTE = tx_ob_ff;
   assign TX_OUT_IS_CRC = tx_oc_ff;
   assign TX_READY = tx_rdy_ff;

   // Receive state
   crc8_word_pkg::word_pos_t rx_pos_ff, nxt_rx_pos;
   logic [7:0] rx_crc_ff, nxt_rx_crc;
   logic [15:0] rx_data_ff, nxt_rx_data; // Word being assembled
   logic rx_wv_ff, nxt_rx_wv;
   logic [15:0] rx_word_ff, nxt_rx_word;
   logic rx_err_ff, nxt_rx_err;

   // Receive next-state logic
   always_comb
   begin
      nxt_rx_pos = rx_pos_ff;
      nxt_rx_crc = rx_crc_ff;
      nxt_rx_data = rx_data_ff;
      nxt_rx_wv = 1'b0;
      nxt_rx_word = rx_word_ff;
      nxt_rx_err = rx_err_ff;
      unique case (rx_pos_ff)
         crc8_word_pkg::POS_MSB:
         begin
            // Command bytes are skipped, no checksum expected
            if (RX_VALID && !RX_CMD)
            begin
               nxt_rx_data = {RX_BYTE, 8'h00};
               nxt_rx_crc = crc_byte(crc8_word_pkg::CRC_SEED, RX_BYTE);
               nxt_rx_pos = crc8_word_pkg::POS_LSB;
            end
         end
         crc8_word_pkg::POS_LSB:
         begin
            if (RX_VALID)
            begin
               nxt_rx_data = {rx_data_ff[15:8], RX_BYTE};
               nxt_rx_crc = crc_byte(rx_crc_ff, RX_BYTE);
               nxt_rx_pos = crc8_word_pkg::POS_CRC;
            end
         end
         crc8_word_pkg::POS_CRC:
         begin
            if (RX_VALID)
            begin
               // Compare received checksum with recomputed one
               nxt_rx_wv = 1'b1;
               nxt_rx_word = rx_data_ff;
               nxt_rx_err = (rx_crc_ff ^ crc8_word_pkg::CRC_XOROUT)
                            != RX_BYTE;
               nxt_rx_pos = crc8_word_pkg::POS_MSB;
            end
         end
      endcase
   end

   // Receive registers
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         rx_pos_ff <= crc8_word_pkg::POS_MSB;
         rx_crc_ff <= crc8_word_pkg::CRC_SEED;
         rx_data_ff <= {crc8_word_pkg::BYTE_RESET, crc8_word_pkg::BYTE_RESET};
         rx_wv_ff <= 1'b0;
         rx_word_ff <= {crc8_word_pkg::BYTE_RESET, crc8_word_pkg::BYTE_RESET};
         rx_err_ff <= 1'b0;
      end
      else if (CE)
      begin
         rx_pos_ff <= nxt_rx_pos;
         rx_crc_ff <= nxt_rx_crc;
         rx_data_ff <= nxt_rx_data;
         rx_wv_ff <= nxt_rx_wv;
         rx_word_ff <= nxt_rx_word;
         rx_err_ff <= nxt_rx_err;
      end
   end

   assign RX_WORD_VALID = rx_wv_ff;
   assign RX_WORD = rx_word_ff;
   assign RX_CRC_ERR = rx_err_ff;

   // Checks on the checksum behaviour
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   known_vector_a: assert property (
      crc_byte(crc_byte(8'hff, 8'hbe), 8'hef) == 8'h92)
      else $error("checksum of known vector wrong");
   crc_follows_a: assert property (
      CE && tx_pos_ff == crc8_word_pkg::POS_LSB && TX_VALID ##1 CE
      |=> TX_OUT_IS_CRC && TX_OUT_VALID)
      else $error("checksum byte did not follow word");
   cmd_no_crc_a: assert property (
      CE && tx_pos_ff == crc8_word_pkg::POS_MSB && TX_VALID && TX_CMD
      |=> tx_pos_ff == crc8_word_pkg::POS_MSB && !TX_OUT_IS_CRC)
      else $error("command byte got a checksum");
   seed_reload_a: assert property (
      CE && tx_pos_ff == crc8_word_pkg::POS_MSB && TX_VALID && !TX_CMD
      |=> tx_crc_ff == crc_byte(8'hff, $past(TX_BYTE)))
      else $error("seed not reloaded for new word");
   crc_value_a: assert property (
      TX_OUT_IS_CRC |-> TX_OUT_BYTE == $past(tx_crc_ff))
      else $error("inserted checksum differs from register");
   rx_check_a: assert property (
      CE && rx_pos_ff == crc8_word_pkg::POS_CRC && RX_VALID
      |=> RX_WORD_VALID && RX_CRC_ERR == ($past(rx_crc_ff) != $past(RX_BYTE)))
      else $error("mismatch flag wrong");
   rx_pulse_a: assert property (
      RX_WORD_VALID && CE |=> !RX_WORD_VALID)
      else $error("word valid longer than one cycle");
   ready_low_a: assert property (
      !TX_READY |-> tx_pos_ff == crc8_word_pkg::POS_CRC)
      else $error("ready low outside checksum slot");

   tx_word_c: cover property (TX_OUT_IS_CRC);
   rx_good_c: cover property (RX_WORD_VALID && !RX_CRC_ERR);
   rx_bad_c: cover property (RX_WORD_VALID && RX_CRC_ERR);
   tx_cmd_c: cover property (CE && TX_VALID && TX_CMD);
endmodule
`default_nettype wire

// File: sim/host_partner.sv
/*
 Host model: sends command and data words into the receive port.
 Assumes its tasks are called at falling edges of REF_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
module host_partner
(
   input wire logic REF_CLK,
   output logic RX_VALID,
   output logic RX_CMD,
   output logic [7:0] RX_BYTE
);
   initial RX_VALID = 1'b0;
   initial RX_CMD = 1'b0;
   initial RX_BYTE = 8'h00;
   // Checksum of one word, bit by bit from the top
   function automatic logic [7:0] crc_of(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--)
      begin
         c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
      end
      return c;
   endfunction
   // One byte for one cycle
   task automatic put(input logic [7:0] b, input logic cmd);
      RX_VALID = 1'b1;
      RX_CMD = cmd;
      RX_BYTE = b;
      @(negedge REF_CLK);
   endtask
   // Idle line shows the inverse of the last byte
   task automatic idle();
      RX_VALID = 1'b0;
      RX_BYTE = ~RX_BYTE;
      @(negedge REF_CLK);
   endtask
   // Command word: no checksum follows
   task automatic send_cmd(input logic [15:0] c);
      put(c[15:8], 1'b1);
      put(c[7:0], 1'b1);
      idle();
   endtask
   // Data word and its checksum, optionally corrupted
   task automatic send_word(input logic [15:0] w, input logic bad);
      put(w[15:8], 1'b0);
      put(w[7:0], 1'b0);
      put(crc_of(w) ^ {7'h00, bad}, 1'b0);
      idle();
   endtask
endmodule
`default_nettype wire

// File: sim/tb_top.sv
/*
 Bench for the word checksum engine: both directions, scoreboarded.
 Assumes host_partner drives the receive port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic CE = 1'b1;
   logic TX_VALID = 1'b0;
   logic TX_CMD = 1'b0;
   logic [7:0] TX_BYTE = 8'h00;
   logic TX_OUT_VALID, TX_OUT_IS_CRC, TX_READY, RX_VALID, RX_CMD;
   logic RX_WORD_VALID, RX_CRC_ERR;
   logic [7:0] TX_OUT_BYTE, RX_BYTE;
   logic [15:0] RX_WORD;
   logic [15:0] w;
   logic [8:0] tx_q[$]; // Expected {is_crc, byte}
   logic [16:0] rx_q[$]; // Expected {err, word}
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   logic ce_seen = 1'b1; // Enable as sampled at the last rising edge
   crc8_word_engine u_crc8_word_engine (.REF_CLK(REF_CLK), .RST(RST),
      .CE(CE), .TX_VALID(TX_VALID), .TX_CMD(TX_CMD), .TX_BYTE(TX_BYTE),
      .TX_OUT_VALID(TX_OUT_VALID), .TX_OUT_BYTE(TX_OUT_BYTE),
      .TX_OUT_IS_CRC(TX_OUT_IS_CRC), .TX_READY(TX_READY),
      .RX_VALID(RX_VALID), .RX_CMD(RX_CMD), .RX_BYTE(RX_BYTE),
      .RX_WORD_VALID(RX_WORD_VALID), .RX_WORD(RX_WORD),
      .RX_CRC_ERR(RX_CRC_ERR));
   host_partner u_host_partner (.REF_CLK(REF_CLK), .RX_VALID(RX_VALID),
      .RX_CMD(RX_CMD), .RX_BYTE(RX_BYTE));
   initial forever #5 REF_CLK = ~REF_CLK;
   // Compare and count
   task automatic check(input string what, input logic [16:0] e,
      input logic [16:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // One transmit cycle
   task automatic tx_put(input logic [7:0] b, input logic c, input logic v);
      TX_VALID = v;
      TX_CMD = c;
      TX_BYTE = b;
      @(negedge REF_CLK);
   endtask
   // Command word: echoed, no checksum expected
   task automatic tx_cmd(input logic [15:0] c);
      tx_q.push_back({1'b0, c[15:8]});
      tx_put(c[15:8], 1'b1, 1'b1);
      tx_q.push_back({1'b0, c[7:0]});
      tx_put(c[7:0], 1'b1, 1'b1);
      tx_put(8'h00, 1'b0, 1'b0);
   endtask
   // Data word; the gap cycle may carry a byte that must be ignored
   task automatic tx_word(input logic [15:0] d, input logic poke);
      tx_q.push_back({1'b0, d[15:8]});
      tx_put(d[15:8], 1'b0, 1'b1);
      tx_q.push_back({1'b0, d[7:0]});
      tx_put(d[7:0], 1'b0, 1'b1);
      check("ready_gap", 17'h0, {16'h0, TX_READY});
      tx_q.push_back({1'b1, u_host_partner.crc_of(d)});
      tx_put(~d[7:0], 1'b0, poke);
      tx_put(8'h00, 1'b0, 1'b0);
   endtask
   // Data word with the clock enable dropped between its bytes
   task automatic tx_stall(input logic [15:0] d);
      tx_q.push_back({1'b0, d[15:8]});
      tx_put(d[15:8], 1'b0, 1'b1);
      CE = 1'b0;
      tx_put(~d[15:8], 1'b0, 1'b1);
      tx_put(~d[15:8], 1'b0, 1'b1);
      CE = 1'b1;
      tx_q.push_back({1'b0, d[7:0]});
      tx_put(d[7:0], 1'b0, 1'b1);
      tx_q.push_back({1'b1, u_host_partner.crc_of(d)});
      tx_put(8'h00, 1'b0, 1'b0);
      tx_put(8'h00, 1'b0, 1'b0);
   endtask
   // Frozen pulses are not new results
   always @(posedge REF_CLK)
   begin
      ce_seen <= CE;
   end
   // Both directions at once
   task automatic both(input logic [15:0] d, input logic f);
      rx_q.push_back({f, d});
      fork
         tx_word(d, f);
         u_host_partner.send_word(d, f);
      join
   endtask
   // Scoreboard and hang guard
   always @(negedge REF_CLK)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         n_mismatch++;
         wrap_up();
      end
      else
      begin
         // Transmit result, or an output nobody expected
         if (ce_seen && TX_OUT_VALID === 1'b1)
         begin
            if (tx_q.size() > 0)
               check("tx_out", {8'h00, tx_q.pop_front()},
                  {8'h00, TX_OUT_IS_CRC, TX_OUT_BYTE});
            else
            begin
               n_mismatch++;
               $display("MISMATCH tx_out expected none seen %h",
                  TX_OUT_BYTE);
            end
         end
         // Receive result, or a word nobody expected
         if (ce_seen && RX_WORD_VALID === 1'b1)
         begin
            if (rx_q.size() > 0)
               check("rx_word", rx_q.pop_front(), {RX_CRC_ERR, RX_WORD});
            else
            begin
               n_mismatch++;
               $display("MISMATCH rx_word expected none seen %h", RX_WORD);
            end
         end
      end
   end
   initial
   begin
      w = 16'($urandom(32'hd017b447));
      repeat (10) @(negedge REF_CLK);
      RST = 1'b0;
      check("ready", 17'h1, {16'h0, TX_READY});
      check("crc_beef", 17'h92, {9'h0, u_host_partner.crc_of(16'hbeef)});
      tx_cmd(16'hd206);
      u_host_partner.send_cmd(16'hd206);
      both(16'hbeef, 1'b0);
      $display("test known_word done");
      for (int i = 0; i < 16; i++)
      begin
         w = 16'($urandom);
         both(w, i[0]);
      end
      $display("test random_words done");
      RST = 1'b1;
      tx_put(8'h00, 1'b0, 1'b0);
      RST = 1'b0;
      check("rst_err", 17'h1, {15'h0, RX_CRC_ERR, TX_READY});
      both(16'h0000, 1'b0);
      $display("test mid_reset done");
      w = 16'($urandom);
      tx_stall(w);
      repeat (4) @(negedge REF_CLK);
      check("left", 17'h0, 17'(tx_q.size() + rx_q.size()));
      $display("test ce_stall done");
      wrap_up();
   end
endmodule
`default_nettype wire
